//--- hdl/level_sync.sv
// Two-stage synchroniser for one level
`timescale 1ns/10ps
module level_sync
(
  input  wire logic clk_in,
  input  wire logic nrst_in,
  input  wire logic level_in,
  output logic      level_out
);
  typedef struct packed {
    logic s1;
    logic s2;
  } sync_type;

  sync_type q;
  sync_type d;

  always_comb
  begin
    d.s1 = level_in;
    d.s2 = q.s1;
  end

  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign level_out = q.s2;
endmodule

//--- hdl/usb_sie_control.sv
// Control logic of the USB serial interface engine: enable, pointers, packet halt, resume
//
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/10ps
module usb_sie_control
#(
  parameter int unsigned RESUME_CYCLES = usb_ctrl_pkg::RESUME_CYCLES_DEF
)
(
  input  wire logic                             clk_in,
  input  wire logic                             nrst_in,
  input  wire logic [usb_ctrl_pkg::ADDR_W-1:0]  addr_in,
  input  wire logic [usb_ctrl_pkg::DATA_W-1:0]  wdata_in,
  input  wire logic                             wr_in,
  input  wire logic                             rd_in,
  output logic      [usb_ctrl_pkg::DATA_W-1:0]  rdata_out,
  input  wire logic                             dp_in,
  input  wire logic                             dm_in,
  input  wire logic                             setup_token_in,
  input  wire logic [usb_ctrl_pkg::NUM_PTR-1:0] ptr_toggle_in,
  output logic      [usb_ctrl_pkg::NUM_PTR-1:0] pingpong_buffer_pointer_out,
  output logic                                  engine_clk_en_out,
  output logic                                  low_power_out,
  output logic                                  pullup_en_out,
  output logic                                  packet_halt_out,
  output logic                                  resume_drive_out,
  output logic                                  tx_idle_out
);
  import usb_ctrl_pkg::*;

  state_type        q;
  state_type        d;
  logic             se0_raw;
  logic             se0_sync;
  logic             ctrl_wr;
  logic             cfg_wr;
  logic             active;
  logic             res_done;
  logic [CNT_W-1:0] res_target;

  // Both lines low is a single-ended zero
  assign se0_raw = ~dp_in & ~dm_in;

  level_sync se0_sync_inst
  (
    .clk_in    (clk_in),
    .nrst_in   (nrst_in),
    .level_in  (se0_raw),
    .level_out (se0_sync)
  );

  assign ctrl_wr    = wr_in && (addr_in == ADDR_CONTROL);
  assign cfg_wr     = wr_in && (addr_in == ADDR_CONFIG);
  assign active     = q.module_enable && !q.suspend;
  assign res_target = CNT_W'(RESUME_CYCLES);
  assign res_done   = q.resume && (q.res_cnt == res_target);

  always_comb
  begin
    d       = q;
    d.rdata = '0;

    // Pointers advance only while packets flow
    if (active && !q.pkt_dis)
    begin
      d.ptr = q.ptr ^ ptr_toggle_in;
    end

    if (ctrl_wr)
    begin
      d.suspend       = wdata_in[BIT_SUSPEND];
      d.resume        = wdata_in[BIT_RESUME];
      d.module_enable = wdata_in[BIT_ENABLE];
      d.ptr_rst       = wdata_in[BIT_PTR_RST];
      // Only a zero is honoured on the packet disable flag
      if (!wdata_in[BIT_PKT_DIS])
      begin
        d.pkt_dis = 1'b0;
      end
      // Turning the module on starts from even buffers
      if (wdata_in[BIT_ENABLE] && !q.module_enable)
      begin
        d.ptr = '0;
      end
    end
    else if (cfg_wr)
    begin
      d.buf_mode = wdata_in[BIT_MODE_LO +: 2];
    end

    // A SETUP token beats a simultaneous software clear
    if (active && setup_token_in)
    begin
      d.pkt_dis = 1'b1;
    end

    // Pointer reset is honoured only in ping-pong modes
    if (q.ptr_rst && (q.buf_mode != MODE_NONE))
    begin
      d.ptr = '0;
    end

    // Measure how long the resume bit has been held, whether or not module enable drives signalling
    if (q.resume)
    begin
      if (q.res_cnt != res_target)
      begin
        d.res_cnt = q.res_cnt + CNT_W'(1);
      end
    end
    else
    begin
      d.res_cnt = '0;
    end

    if (rd_in)
    begin
      if (addr_in == ADDR_CONTROL)
      begin
        d.rdata[BIT_SUSPEND] = q.suspend;
        d.rdata[BIT_RESUME]  = q.resume;
        d.rdata[BIT_ENABLE]  = q.module_enable;
        d.rdata[BIT_PKT_DIS] = q.pkt_dis;
        d.rdata[BIT_SE0]     = se0_sync;
        d.rdata[BIT_PTR_RST] = q.ptr_rst;
      end
      else if (addr_in == ADDR_CONFIG)
      begin
        d.rdata[BIT_MODE_LO +: 2] = q.buf_mode;
      end
      else if (addr_in == ADDR_PTR_LO)
      begin
        d.rdata = q.ptr[7:0];
      end
      else if (addr_in == ADDR_PTR_HI)
      begin
        d.rdata = q.ptr[15:8];
      end
      else if (addr_in == ADDR_STATUS)
      begin
        d.rdata[BIT_RES_DONE] = res_done;
        d.rdata[BIT_ACTIVE]   = active;
      end
      else
      begin
        d.rdata = '0;
      end
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      q <= STATE_RESET;
    end
    else
    begin
      q <= d;
    end
  end

  assign rdata_out                   = q.rdata;
  assign pingpong_buffer_pointer_out = q.ptr;
  // Suspend gates the engine clock and enters low power
  assign engine_clk_en_out           = active;
  assign low_power_out               = q.suspend;
  // Pull-ups follow enable alone, so suspend keeps the device attached
  assign pullup_en_out               = q.module_enable;
  // Halt stops new packets only; the transfer status queue is never flushed here
  assign packet_halt_out             = q.pkt_dis;
  assign resume_drive_out            = q.module_enable && q.resume;
  assign tx_idle_out                 = q.suspend && !q.resume;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);

  se0_flag_a: assert property (se0_raw |-> ##2 se0_sync)
    else $error("se0 flag not seen two cycles after the lines went low");

  enable_clear_a: assert property
    (ctrl_wr && wdata_in[BIT_ENABLE] && !q.module_enable && !q.ptr_rst
     |=> (pingpong_buffer_pointer_out == '0) && engine_clk_en_out == !q.suspend)
    else $error("pointers not cleared when module was enabled");

  pullup_attach_a: assert property
    ($rose(q.module_enable) |-> pullup_en_out && $past(ctrl_wr))
    else $error("pull-ups do not follow module enable");

  ptr_force_a: assert property
    (q.ptr_rst && (q.buf_mode != MODE_NONE) |=> pingpong_buffer_pointer_out == '0)
    else $error("pointer reset did not force even buffers");

  ptr_ignore_a: assert property
    (q.ptr_rst && (q.buf_mode == MODE_NONE) && active && !q.pkt_dis && !ctrl_wr
     && (ptr_toggle_in != '0)
     |=> pingpong_buffer_pointer_out == ($past(q.ptr) ^ $past(ptr_toggle_in)))
    else $error("pointer reset acted in non ping-pong mode");

  setup_halt_a: assert property
    (active && setup_token_in |=> packet_halt_out [*2] or ##1 $past(ctrl_wr))
    else $error("setup token did not halt packets");

  pkt_set_ign_a: assert property
    (!q.pkt_dis && ctrl_wr && wdata_in[BIT_PKT_DIS] && !setup_token_in
     |=> !packet_halt_out)
    else $error("software managed to set packet disable");

  pkt_clear_a: assert property
    (q.pkt_dis && ctrl_wr && !wdata_in[BIT_PKT_DIS] && !(active && setup_token_in)
     |=> !packet_halt_out)
    else $error("packet disable not cleared by writing zero");

  resume_drive_a: assert property
    (q.resume && q.module_enable |-> resume_drive_out)
    else $error("resume set but no resume signalling");

  suspend_gate_a: assert property
    (q.suspend |-> !engine_clk_en_out && low_power_out)
    else $error("engine clock still running in suspend");

  suspend_attach_a: assert property
    (q.suspend && q.module_enable && !q.resume |-> pullup_en_out && tx_idle_out)
    else $error("suspended device detached or transceiver not idle");

  pkt_hold_a: assert property
    (q.pkt_dis && !ctrl_wr |=> packet_halt_out)
    else $error("packet disable dropped without a clearing write");

  rdata_idle_a: assert property
    (!$past(rd_in) |-> rdata_out == '0)
    else $error("read data shown without a read strobe");

  se0_read_a: assert property
    (rd_in && (addr_in == ADDR_CONTROL) |=> rdata_out[BIT_SE0] == $past(se0_sync))
    else $error("se0 flag read back wrong");

  ptr_rst_c:     cover property (q.ptr_rst && (q.buf_mode != MODE_NONE) ##1 q.module_enable);
  setup_clear_c: cover property (setup_token_in && active ##[1:20] !packet_halt_out);
  resume_done_c: cover property (res_done);
  suspend_c:     cover property (q.module_enable ##1 q.suspend);
endmodule

//--- inc/usb_ctrl_pkg.sv
// Constants, register map and state type for the USB engine control block
//
// Contract
// - Software can read a flag showing a single-ended zero on the data lines.
// - Setting module enable starts the engine and clears all ping-pong pointers.
// - Bus pull-ups are on while module enable is set: soft attach.
// - While pointer reset is set in ping-pong mode, all pointers select even.
// - Pointer reset is ignored when the buffering mode has no ping-pong buffers.
// - A SETUP token sets packet disable and halts packet traffic; the code ignores it unless module enable is set and suspend is clear.
// - Software writing 1 to packet disable has no effect; only clearing works.
// - Once packet disable is cleared, packet traffic resumes.
// - Pending transfer status entries stay available while packets are halted.
// - While resume is set, resume signalling is driven onto the bus; the code drives it only while module enable is also set.
// - Suspend puts the engine in low power and gates its clock off.
// - While suspended the device stays attached with idle transceiver outputs; the code holds tx_idle_out low while resume is set.
package usb_ctrl_pkg;

  localparam int unsigned ADDR_W  = 4;
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned NUM_PTR = 16;
  localparam int unsigned CNT_W   = 17;

  // Register offsets
  localparam logic [ADDR_W-1:0] ADDR_CONTROL = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_CONFIG  = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_PTR_LO  = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_PTR_HI  = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_STATUS  = 4'h4;

  // Control register fields
  localparam int unsigned BIT_SUSPEND  = 1;
  localparam int unsigned BIT_RESUME   = 2;
  localparam int unsigned BIT_ENABLE   = 3;
  localparam int unsigned BIT_PKT_DIS  = 4;
  localparam int unsigned BIT_SE0      = 5;
  localparam int unsigned BIT_PTR_RST  = 6;

  // Config register: buffering mode in the low two bits
  localparam int unsigned BIT_MODE_LO  = 0;
  localparam logic [1:0]  MODE_NONE    = 2'h0;

  // Status register fields
  localparam int unsigned BIT_RES_DONE = 0;
  localparam int unsigned BIT_ACTIVE   = 1;

  // Resume duration
  localparam int unsigned CLK_FREQ_HZ       = 10000000;
  localparam int unsigned RESUME_TIME_MS    = 10;
  localparam int unsigned RESUME_CYCLES_DEF = RESUME_TIME_MS * (CLK_FREQ_HZ / 1000);

  typedef struct packed {
    logic               module_enable;
    logic               suspend;
    logic               resume;
    logic               pkt_dis;
    logic               ptr_rst;
    logic [1:0]         buf_mode;
    logic [NUM_PTR-1:0] ptr;
    logic [CNT_W-1:0]   res_cnt;
    logic [DATA_W-1:0]  rdata;
  } state_type;

  localparam state_type STATE_RESET = '{
    module_enable: 1'b0,
    suspend:       1'b0,
    resume:        1'b0,
    pkt_dis:       1'b0,
    ptr_rst:       1'b0,
    buf_mode:      2'h0,
    ptr:           16'h0000,
    res_cnt:       17'h00000,
    rdata:         8'h00
  };

endpackage

//--- verif/tb_top.sv
// Self-checking bench for the USB engine control block
`timescale 1ns/10ps
module tb_top;
  import usb_ctrl_pkg::*;
  localparam int RC = 8;
  logic        clk_in, nrst_in, wr_in, rd_in, se0, stp, dp, dm, stp_t;
  logic [3:0]  addr_in;
  logic [7:0]  wdata_in, rdata_out, got;
  logic [15:0] tog, tog_t, ptr, lf;
  logic        ck_en, lowp, pull, halt, resd, txi;
  int          failures, checks, en, sus, res, pkt, prst, mode, mptr, s0;

  usb_far_model u_usb_far_model (.clk_in(clk_in), .se0_in(se0), .setup_in(stp),
    .tog_in(tog), .dp_out(dp), .dm_out(dm), .setup_out(stp_t), .tog_out(tog_t));
  usb_sie_control #(.RESUME_CYCLES(RC)) u_usb_sie_control (.clk_in(clk_in),
    .nrst_in(nrst_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
    .rd_in(rd_in), .rdata_out(rdata_out), .dp_in(dp), .dm_in(dm), .setup_token_in(stp_t),
    .ptr_toggle_in(tog_t), .pingpong_buffer_pointer_out(ptr), .engine_clk_en_out(ck_en),
    .low_power_out(lowp), .pullup_en_out(pull), .packet_halt_out(halt),
    .resume_drive_out(resd), .tx_idle_out(txi));

  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  task automatic final_report();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk_reg(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e)
    begin
      failures++;
      $display("MISMATCH %0t read got %h exp %h", $time, g, e);
    end
  endtask

  task automatic chk_pin(input logic g, input logic e);
    checks++;
    if (g !== e)
    begin
      failures++;
      $display("MISMATCH %0t pin got %b exp %b", $time, g, e);
    end
  endtask

  // One strobe cycle; read data land in the cycle after the strobe edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr_in <= w;
    rd_in <= !w;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
    rd_in <= 1'b0;
    @(negedge clk_in);
    got = rdata_out;
  endtask

  task automatic wctl(input logic [7:0] d);
    bus(1'b1, ADDR_CONTROL, d);
    if (d[3] && en == 0) mptr = 0;
    sus = d[1];
    res = d[2];
    en = d[3];
    prst = d[6];
    if (!d[4]) pkt = 0;
    if (prst != 0 && mode != 0) mptr = 0;
  endtask

  task automatic pins();
    chk_pin(pull, en != 0);
    chk_pin(ck_en, en != 0 && sus == 0);
    chk_pin(lowp, sus != 0);
    chk_pin(halt, pkt != 0);
    chk_pin(resd, en != 0 && res != 0);
    chk_pin(txi, sus != 0 && res == 0);
    bus(1'b0, ADDR_CONTROL, 8'h00);
    chk_reg(got & 8'h7e, {1'b0, prst[0], s0[0], pkt[0], en[0], res[0], sus[0], 1'b0});
  endtask

  task automatic burst(input int n);
    for (int i = 0; i < n; i++)
    begin
      lf = lfsr(lf);
      @(posedge clk_in);
      tog <= lf;
      if (en != 0 && sus == 0 && pkt == 0 && !(prst != 0 && mode != 0)) mptr = mptr ^ int'(lf);
    end
    @(posedge clk_in);
    tog <= 16'h0000;
    repeat (3) @(posedge clk_in);
    bus(1'b0, ADDR_PTR_LO, 8'h00);
    chk_reg(got, 8'(mptr));
    bus(1'b0, ADDR_PTR_HI, 8'h00);
    chk_reg(got, 8'(mptr >> 8));
  endtask

  task automatic setup();
    @(posedge clk_in);
    stp <= 1'b1;
    @(posedge clk_in);
    stp <= 1'b0;
    if (en != 0 && sus == 0) pkt = 1;
    repeat (3) @(posedge clk_in);
  endtask

  initial
  begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  initial
  begin
    repeat (3000) @(posedge clk_in);
    failures++;
    $display("MISMATCH %0t watchdog expired", $time);
    final_report();
  end

  initial
  begin
    {nrst_in, wr_in, rd_in, addr_in, wdata_in, se0, stp, tog} = '0;
    lf = 16'h0023;
    {en, sus, res, pkt, prst, mode, mptr, s0} = '0;
    repeat (20) @(posedge clk_in);
    nrst_in <= 1'b1;
    @(negedge clk_in);
    pins();
    bus(1'b1, ADDR_CONFIG, 8'h01);
    mode = 1;
    wctl(8'h08);
    pins();
    burst(20);
    wctl(8'h00);
    pins();
    wctl(8'h08);
    burst(0);
    setup();
    pins();
    burst(10);
    wctl(8'h18);
    pins();
    wctl(8'h08);
    pins();
    burst(10);
    wctl(8'h48);
    burst(10);
    wctl(8'h08);
    burst(6);
    bus(1'b1, ADDR_CONFIG, 8'h00);
    mode = 0;
    wctl(8'h48);
    burst(6);
    wctl(8'h08);
    se0 <= 1'b1;
    repeat (4) @(posedge clk_in);
    s0 = 1;
    pins();
    se0 <= 1'b0;
    repeat (4) @(posedge clk_in);
    s0 = 0;
    pins();
    wctl(8'h0c);
    pins();
    repeat (RC + 2) @(posedge clk_in);
    bus(1'b0, ADDR_STATUS, 8'h00);
    chk_reg(got & 8'h01, 8'h01);
    wctl(8'h08);
    wctl(8'h0a);
    pins();
    setup();
    pins();
    wctl(8'h08);
    pins();
    bus(1'b0, 4'hf, 8'h00);
    chk_reg(got, 8'h00);
    final_report();
  end
endmodule

//--- verif/usb_far_model.sv
// Far-side model: bus line levels, SETUP tokens and pointer toggles
`timescale 1ns/10ps
module usb_far_model
(
  input  wire logic        clk_in,
  input  wire logic        se0_in,
  input  wire logic        setup_in,
  input  wire logic [15:0] tog_in,
  output logic             dp_out,
  output logic             dm_out,
  output logic             setup_out,
  output logic [15:0]      tog_out
);
  initial
  begin
    dp_out = 1'b1;
    dm_out = 1'b0;
    setup_out = 1'b0;
    tog_out = 16'h0000;
  end
  // Idle bus shows J; a bus reset pulls both lines low
  always @(posedge clk_in)
  begin
    dp_out <= !se0_in;
    dm_out <= 1'b0;
    setup_out <= setup_in;
    tog_out <= tog_in;
  end
endmodule
